// [rtl/nvm_timing_pkg.sv]
// package: constants and types for the nvm program/erase timing core
package nvm_timing_pkg;
  localparam int unsigned CLK_FREQ_HZ        = 40000000;
  localparam int unsigned DIV_W              = 8;
  localparam logic [7:0]  DIV_RESET          = 8'h00;
  // operation and bus clock counts per operation, and word counts
  localparam logic [15:0] SWP_OP_CYC         = 16'h0009;  // 9 op periods
  localparam logic [15:0] SWP_BUS_CYC        = 16'h0019;  // 25 bus periods
  localparam logic [15:0] BWP_OP_CYC         = 16'h0004;  // 4 op periods
  localparam logic [15:0] BWP_BUS_CYC        = 16'h0009;  // 9 bus periods
  localparam logic [5:0]  ROW_WORDS          = 6'h20;     // 32 words per row
  localparam logic [15:0] ERA_OP_CYC         = 16'h0FA0;  // 4000 op periods
  localparam logic [15:0] MASS_OP_CYC        = 16'h4E20;  // 20000 op periods
  localparam logic [15:0] CHK_SETUP_CYC      = 16'h000A;  // 10 bus cycles setup
  localparam logic [15:0] CODE_WORDS         = 16'h8000;  // 32768 words, 32778 max
  localparam logic [15:0] DATA_WORDS         = 16'h0800;  // 2048 words, 2058 max

  typedef enum logic [2:0] {
    CMD_WORD_PGM,
    CMD_SECTOR_ERASE,
    CMD_MASS_ERASE,
    CMD_BLANK_CHECK
  } nvm_cmd_t;

  typedef struct packed {
    logic     valid;     // request strobe
    nvm_cmd_t cmd;       // operation
    logic     data_mem;  // 1 selects the data memory
  } nvm_req_t;

  typedef struct packed {
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] cnt_q;
    logic             tick_q;
  } div_state_t;
endpackage

// [rtl/nvm_op_clock_divider.sv]
// operation clock tick generator divided down from the oscillator clock
`timescale 1ns/10ps
module nvm_op_clock_divider (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst_b,    // async reset, active low
  input  wire logic [7:0] div_in,   // divider setting, tick every div_in+1 clocks
  output logic            op_tick   // one-cycle operation clock tick
);
  nvm_timing_pkg::div_state_t s_q, s_d;

  // free-running counter; no frequency check, any setting is accepted
  always_comb begin
    s_d        = s_q;
    s_d.div_q  = div_in;
    s_d.tick_q = 1'b0;
    if (s_q.cnt_q >= s_q.div_q) begin
      s_d.cnt_q  = '0;
      s_d.tick_q = 1'b1;
    end else begin
      s_d.cnt_q = s_q.cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign op_tick = s_q.tick_q;
endmodule

// [rtl/nvm_program_erase_timing.sv]
// timing core of the nvm command sequencer for code and data memory
// Notes on behaviour
// - program and erase are timed by an operation clock divided from the oscillator, one divider per memory.
// - the frequency is never checked and commands are never blocked for a bad setting.
// - a single word program lasts 9 operation periods plus 25 bus periods.
// - code memory programs up to 32 words of a row back to back while the next word is queued in time.
// - each following burst word lasts 4 operation periods plus 9 bus periods.
// - a full row burst is one single word time plus 31 burst word times.
// - only the code memory bursts; data memory words are programmed one at a time.
// - a sector erase lasts 4000 operation periods, sector size being 512 bytes or 4 bytes.
// - a mass erase lasts 20000 operation periods.
// - blank check reads one word per bus cycle from address zero, stops at the first non-blank word, plus 10 setup cycles.
// - blank check takes at least 11 cycles and at most 32778 (code) or 2058 (data) cycles.
`timescale 1ns/10ps
module nvm_program_erase_timing (
  input  wire logic                     clk_sys,          // bus clock
  input  wire logic                     rst_b,            // async reset, active low
  input  wire logic                     osc_tick,         // unused reference, oscillator runs clk domain
  input  wire logic [7:0]               code_mem_clock_divider, // code memory divider setting
  input  wire logic [7:0]               data_mem_clock_divider, // data memory divider setting
  input  wire nvm_timing_pkg::nvm_req_t req,              // command request
  output logic                          req_ready,        // request accepted this cycle
  output logic                          busy,             // operation in progress
  output logic                          done,             // one-cycle completion pulse
  output logic [15:0]                   check_addr,       // blank check word address
  output logic                          check_rd,         // blank check read strobe
  input  wire logic                     check_blank,      // read word is blank
  output logic                          check_fail,       // blank check found data
  output logic                          pgm_strobe        // word committed to array
);

  // a program word runs ST_BUS then ST_OP; erase has no bus-clock share and goes
  // straight to ST_OP, blank check runs its setup and then the scan
  typedef enum logic [2:0] {
    ST_IDLE, ST_BUS, ST_OP, ST_CHK_SETUP, ST_CHK_SCAN
  } state_t;

  // all sequencer state in one word; cnt times the bus-clock shares, op_cnt the
  // operation-clock share, so a word program is simply two phases in a row
  typedef struct packed {
    state_t      st;
    logic [15:0] cnt;        // remaining cycles in current phase
    logic [15:0] op_cnt;     // op periods still to do after bus phase
    logic        burst;      // currently inside a code memory row burst
    logic [5:0]  words;      // words done in the current row
    logic        data_mem;
    logic [15:0] addr;
    logic        done;
    logic        fail;
    logic        pgm;
    logic        is_pgm;     // current operation writes a word
  } state_s_t;

  // registered state and its next value; the tick nets come from the two dividers
  state_s_t s_q, s_d;
  logic code_tick, data_tick, op_tick;

  // one divider per memory, the sequencer follows the selected one
  nvm_op_clock_divider u_code_div (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .div_in  (code_mem_clock_divider),
    .op_tick (code_tick)
  );

  // data memory divider, paced on its own so the two memories may differ
  nvm_op_clock_divider u_data_div (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .div_in  (data_mem_clock_divider),
    .op_tick (data_tick)
  );

  // only one memory is worked at a time, so the selected divider alone paces the
  // sequencer; the other divider keeps running and costs only a little power
  assign op_tick = s_q.data_mem ? data_tick : code_tick;

  // a program request queued while a code word finishes keeps the row burst alive;
  // the count includes the word now ending, so the last word of a row never offers
  // a continuation that the state machine would then drop
  logic burst_cont;
  assign burst_cont = req.valid && req.cmd == nvm_timing_pkg::CMD_WORD_PGM && !req.data_mem
                      && !s_q.data_mem
                      && (s_q.words + 6'h01) < nvm_timing_pkg::ROW_WORDS;

  // accept anything when idle; no check of divider range
  // while busy a request is only taken on the last operation tick of a burst word,
  // the same cycle in which the next state moves on to the following word
  assign req_ready = (s_q.st == ST_IDLE) ||
                     (s_q.st == ST_OP && s_q.pgm == 1'b0 && s_q.op_cnt == 16'h0001 && op_tick
                      && s_q.burst && burst_cont);

  // next-state logic; done and pgm are cleared here every cycle so they can only
  // ever be one-cycle pulses, whatever path sets them
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.pgm  = 1'b0;
    unique case (s_q.st)
      // a fresh command clears the scan result and the row count of any earlier one
      ST_IDLE: begin
        if (req.valid) begin
          s_d.data_mem = req.data_mem;
          s_d.fail     = 1'b0;
          s_d.words    = 6'h00;
          s_d.burst    = 1'b0;
          s_d.is_pgm   = req.cmd == nvm_timing_pkg::CMD_WORD_PGM;
          unique case (req.cmd)
            // a code word opens a possible row burst, a data word never does
            nvm_timing_pkg::CMD_WORD_PGM: begin
              s_d.st     = ST_BUS;
              s_d.cnt    = nvm_timing_pkg::SWP_BUS_CYC;
              s_d.op_cnt = nvm_timing_pkg::SWP_OP_CYC;
              s_d.burst  = !req.data_mem;
            end

            // erase has no bus-clock share; the sector size only matters to the array
            nvm_timing_pkg::CMD_SECTOR_ERASE: begin
              s_d.st     = ST_OP;
              s_d.op_cnt = nvm_timing_pkg::ERA_OP_CYC;    // setup ignored
            end

            // the same wait as a sector erase, only five times longer
            nvm_timing_pkg::CMD_MASS_ERASE: begin
              s_d.st     = ST_OP;
              s_d.op_cnt = nvm_timing_pkg::MASS_OP_CYC;
            end

            // the scan always starts at word zero of the selected block
            nvm_timing_pkg::CMD_BLANK_CHECK: begin
              s_d.st   = ST_CHK_SETUP;
              s_d.cnt  = nvm_timing_pkg::CHK_SETUP_CYC;
              s_d.addr = 16'h0000;
            end
            default: s_d.st = ST_IDLE;
          endcase
        end
      end

      // bus clock share of a program word
      // the count is loaded with the full share and left at one on the way out
      ST_BUS: begin
        if (s_q.cnt <= 16'h0001) begin
          s_d.st = ST_OP;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end

      // operation clock share; counts only on divider ticks
      // a slow divider stretches only this phase, so a bad setting still ends
      ST_OP: begin
        if (op_tick) begin
          if (s_q.op_cnt <= 16'h0001) begin
            s_d.done = 1'b1;
            // only a program word commits data; an erase ends with done alone
            s_d.pgm  = s_q.is_pgm;
            s_d.st   = ST_IDLE;
            // the row count only moves inside a code memory burst
            if (s_q.burst) begin
              s_d.words = s_q.words + 6'h01;
              if (burst_cont && s_q.words + 6'h01 < nvm_timing_pkg::ROW_WORDS) begin
                // next word of the row at the shorter burst rate
                s_d.st     = ST_BUS;
                s_d.cnt    = nvm_timing_pkg::BWP_BUS_CYC;
                s_d.op_cnt = nvm_timing_pkg::BWP_OP_CYC;
              end
            end
          end else begin
            s_d.op_cnt = s_q.op_cnt - 16'h0001;
          end
        end
      end

      // fixed command setup before the first word is read
      ST_CHK_SETUP: begin
        if (s_q.cnt <= 16'h0001) begin
          s_d.st = ST_CHK_SCAN;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end

      // one word per bus cycle, stop on first non-blank word
      // a clean scan ends on the last word of the selected block
      ST_CHK_SCAN: begin
        // a non-blank word ends the scan at once and is reported through check_fail
        if (!check_blank) begin
          s_d.fail = 1'b1;
          s_d.done = 1'b1;
          s_d.st   = ST_IDLE;
        end else if (s_q.addr == (s_q.data_mem ? nvm_timing_pkg::DATA_WORDS : nvm_timing_pkg::CODE_WORDS)
                                 - 16'h0001) begin
          s_d.done = 1'b1;
          s_d.st   = ST_IDLE;
        end else begin
          s_d.addr = s_q.addr + 16'h0001;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // state register; reset leaves the sequencer idle with every pulse low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q    <= '0;
      // restated so the idle state does not hinge on its encoding
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register; busy and check_rd are decodes of
  // the state, the data-like outputs are flops
  assign busy       = s_q.st != ST_IDLE;
  assign done       = s_q.done;
  assign check_addr = s_q.addr;
  assign check_rd   = s_q.st == ST_CHK_SCAN;
  assign check_fail = s_q.fail;
  assign pgm_strobe = s_q.pgm;
endmodule

// [testbench/nvm_timing_asserts.sv]
// checker for the nvm program/erase timing core ports
`timescale 1ns/10ps
module nvm_timing_asserts (
  input wire logic                     clk_sys,     // clock
  input wire logic                     rst_b,       // reset
  input wire nvm_timing_pkg::nvm_req_t req,         // request
  input wire logic                     req_ready,   // taken
  input wire logic                     busy,        // running
  input wire logic                     done,        // end pulse
  input wire logic [15:0]              check_addr,  // scan address
  input wire logic                     check_rd,    // scan strobe
  input wire logic                     check_blank, // word blank
  input wire logic                     check_fail,  // data found
  input wire logic                     pgm_strobe   // word written
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic take;
  logic chk_take;
  // request taken at this edge
  assign take = req.valid && req_ready;
  assign chk_take = take && req.cmd == nvm_timing_pkg::CMD_BLANK_CHECK;
  a_done_pulse: assert property (done |=> !done) else $error("done wider than one cycle");
  a_idle_take: assert property (req.valid && !busy |-> req_ready) else $error("idle request refused");
  a_take_busy: assert property (take |=> busy) else $error("taken request not busy");
  a_strobe_done: assert property (pgm_strobe |-> done) else $error("strobe without done");
  a_check_setup: assert property (chk_take |-> ##11 (check_rd && check_addr == 16'h0000))
    else $error("scan start misplaced");
  a_check_min: assert property (chk_take |=> !done [*8]) else $error("blank check too short");
  a_scan_stop: assert property (check_rd && !check_blank |=> done && check_fail)
    else $error("scan did not stop on data");
  a_scan_step: assert property (check_rd && check_blank ##1 check_rd |-> check_addr == $past(check_addr) + 16'h0001)
    else $error("scan address skipped");
  a_fail_hold: assert property (check_fail && !take |=> check_fail) else $error("fail flag dropped");
  c_mass: cover property (take && req.cmd == nvm_timing_pkg::CMD_MASS_ERASE);
  c_stop: cover property (check_rd && !check_blank);
  c_burst: cover property (pgm_strobe ##[1:30] pgm_strobe);
endmodule
bind nvm_program_erase_timing nvm_timing_asserts chk (.clk_sys, .rst_b, .req, .req_ready, .busy, .done,
  .check_addr, .check_rd, .check_blank, .check_fail, .pgm_strobe);

// [testbench/nvm_array_model.sv]
// array model answering blank check reads
`timescale 1ns/10ps
module nvm_array_model (
  input  wire logic        clk_sys,     // clock
  input  wire logic [15:0] check_addr,  // word address
  input  wire logic        check_rd,    // read strobe
  input  wire logic [15:0] dirty_addr,  // first non-blank word
  output logic             check_blank  // word is blank
);
  logic toggle_q = 1'b0;
  // nothing is driven outside reads, so the line wanders every cycle
  always_ff @(posedge clk_sys) begin
    toggle_q <= ~toggle_q;
  end
  assign check_blank = check_rd ? (check_addr < dirty_addr) : toggle_q;
endmodule

// [testbench/test_nvm_program_erase_timing.sv]
// testbench for the nvm program/erase timing core
`timescale 1ns/10ps
module test_nvm_program_erase_timing;
  logic                     clk_sys = 1'b0;
  logic                     rst_b = 1'b0;
  logic [7:0]               cdiv = 8'h00;
  logic [7:0]               ddiv = 8'h00;
  logic [15:0]              dirty = 16'h0000;
  nvm_timing_pkg::nvm_req_t req = '0;
  logic                     req_ready, busy, done, check_rd, check_blank, check_fail, pgm_strobe;
  logic [15:0]              check_addr;
  int                       num_errors = 0;
  int                       checks = 0;
  nvm_program_erase_timing dut (.clk_sys, .rst_b, .osc_tick(1'b0), .code_mem_clock_divider(cdiv),
    .data_mem_clock_divider(ddiv), .req, .req_ready, .busy, .done, .check_addr, .check_rd,
    .check_blank, .check_fail, .pgm_strobe);
  nvm_array_model far (.clk_sys, .check_addr, .check_rd, .dirty_addr(dirty), .check_blank);
  // 40 MHz bus clock
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // issue n requests, hold valid until the n-th is taken, time first take to last done
  task automatic op(input nvm_timing_pkg::nvm_cmd_t cmd, input logic dm, input int n, input int lo,
                    input int hi, input logic fail);
    int k = 0, tk = 0, dn = 0, st = 0, last = 0;
    @(posedge clk_sys);
    req <= '{valid: 1'b1, cmd: cmd, data_mem: dm};
    while (dn < n && k < 30000) begin
      @(negedge clk_sys);
      k++;
      if (done) begin
        dn++;
        last = k;
      end
      if (pgm_strobe) st++;
      if (req.valid && req_ready) begin
        tk++;
        if (tk == n) begin
          @(posedge clk_sys);
          req.valid <= 1'b0;
        end
      end
    end
    chk("op time in range", 32'h1, {31'h0, last - 1 >= lo && last - 1 <= hi});
    chk("program strobes", (cmd == nvm_timing_pkg::CMD_WORD_PGM) ? n : 0, st);
    chk("check fail flag", {31'h0, fail}, {31'h0, check_fail});
  endtask
  // divider 0 runs the operation clock far above its band and the word still runs
  task automatic s_single; op(nvm_timing_pkg::CMD_WORD_PGM, 1'b0, 1, 33, 35, 1'b0); endtask
  task automatic s_burst; op(nvm_timing_pkg::CMD_WORD_PGM, 1'b0, 32, 435, 439, 1'b0); endtask
  // data memory on a slower divider: two words never merge into a burst
  task automatic s_data_words;
    @(posedge clk_sys);
    ddiv <= 8'h03;
    op(nvm_timing_pkg::CMD_WORD_PGM, 1'b1, 2, 116, 130, 1'b0);
  endtask
  task automatic s_erase;
    op(nvm_timing_pkg::CMD_SECTOR_ERASE, 1'b0, 1, 3998, 4002, 1'b0);
    @(posedge clk_sys);
    ddiv <= 8'h01;
    op(nvm_timing_pkg::CMD_SECTOR_ERASE, 1'b1, 1, 7996, 8004, 1'b0);
  endtask
  task automatic s_mass; op(nvm_timing_pkg::CMD_MASS_ERASE, 1'b0, 1, 19998, 20002, 1'b0); endtask
  task automatic s_check_dirty;
    dirty <= 16'h0000;
    op(nvm_timing_pkg::CMD_BLANK_CHECK, 1'b0, 1, 10, 12, 1'b1);
    dirty <= 16'h0005;
    op(nvm_timing_pkg::CMD_BLANK_CHECK, 1'b0, 1, 15, 17, 1'b1);
  endtask
  task automatic s_check_blank;
    dirty <= 16'hFFFF;
    op(nvm_timing_pkg::CMD_BLANK_CHECK, 1'b1, 1, 2057, 2059, 1'b0);
  endtask
  // the slowest setting gives about 156 kHz, outside the band software must keep
  task automatic s_bad_div;
    @(posedge clk_sys);
    cdiv <= 8'hFF;
    op(nvm_timing_pkg::CMD_WORD_PGM, 1'b0, 1, 2100, 2360, 1'b0);
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    s_single();
    s_burst();
    s_data_words();
    s_erase();
    s_mass();
    s_check_dirty();
    s_single();
    s_check_blank();
    s_bad_div();
    end_of_test();
  end
  // the whole run needs about 40000 cycles
  initial begin
    #1500000;
    num_errors++;
    end_of_test();
  end
endmodule
